// file: common/stepper_pkg.sv
// Shared constants, field layouts and decode tables of the micro-step sequencer
package stepper_pkg;

  // ********************************************************
  // Clock and timing
  // ********************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int IDLE_SHORT_MS = 520;
  localparam int IDLE_LONG_MS = 1040;
  localparam int IDLE_SHORT_CYCLES = IDLE_SHORT_MS * (CLK_HZ / 1000);
  localparam int IDLE_LONG_CYCLES = IDLE_LONG_MS * (CLK_HZ / 1000);
  localparam int IDLE_CNT_W = 26;
  localparam int CHOP_BASE_NS = 8000;
  localparam int CHOP_BASE_CYCLES = CHOP_BASE_NS / CLK_PERIOD_NS;
  localparam int CHOP_CNT_W = 11;

  // ********************************************************
  // Serial words and register fields
  // ********************************************************
  localparam int WORD_BITS = 8;
  localparam logic [1:0] ADDR_STEP_FAULT = 2'h0;
  localparam logic [1:0] ADDR_CURRENT_TIMEOUT = 2'h1;
  localparam logic [1:0] ADDR_CHOP = 2'h2;
  localparam int RES_LSB = 2;
  localparam int FAULT_SEL_LSB = 6;
  localparam int REF_ATT_LSB = 2;
  localparam int DECAY_LSB = 5;
  localparam int IDLE_SEL_BIT = 7;
  localparam int CHOP_SEL_LSB = 6;
  localparam logic [3:0] RES_RESET = 4'h0;
  localparam logic [2:0] REF_ATT_RESET = 3'h0;
  localparam logic [1:0] CHOP_SEL_RESET = 2'h0;
  localparam logic IDLE_SEL_RESET = 1'b0;

  typedef enum logic [1:0] {
    DECAY_MIXED25 = 2'b00,
    DECAY_MIXED50 = 2'b01,
    DECAY_SLOW = 2'b10,
    DECAY_FAST = 2'b11
  } decay_t;

  typedef enum logic [1:0] {
    FSEL_OVERCURRENT = 2'b00,
    FSEL_NONE = 2'b01,
    FSEL_UNDERVOLT = 2'b10,
    FSEL_THERMAL = 2'b11
  } fault_sel_t;

  typedef enum logic {
    CHOP_CHARGE = 1'b0,
    CHOP_DECAY = 1'b1
  } chop_state_t;

  // Steps in one quarter of the electrical cycle for each resolution code
  function automatic logic [7:0] steps_per_quarter(input logic [3:0] code);
    unique case (code)
      4'h0: steps_per_quarter = 8'h02;
      4'h1: steps_per_quarter = 8'h04;
      4'h2: steps_per_quarter = 8'h08;
      4'h3: steps_per_quarter = 8'h10;
      4'h4: steps_per_quarter = 8'h20;
      4'h5: steps_per_quarter = 8'h40;
      4'h6: steps_per_quarter = 8'h80;
      4'h7: steps_per_quarter = 8'h03;
      4'h8: steps_per_quarter = 8'h06;
      4'h9: steps_per_quarter = 8'h0C;
      4'hA: steps_per_quarter = 8'h24;
      4'hB: steps_per_quarter = 8'h05;
      4'hC: steps_per_quarter = 8'h0A;
      4'hD: steps_per_quarter = 8'h14;
      4'hE: steps_per_quarter = 8'h32;
      4'hF: steps_per_quarter = 8'h64;
    endcase
  endfunction

  // Rounded-up 65536/N, so that n*scale>>8 maps a quarter onto 0..256
  function automatic logic [15:0] angle_scale(input logic [3:0] code);
    unique case (code)
      4'h0: angle_scale = 16'h8000;
      4'h1: angle_scale = 16'h4000;
      4'h2: angle_scale = 16'h2000;
      4'h3: angle_scale = 16'h1000;
      4'h4: angle_scale = 16'h0800;
      4'h5: angle_scale = 16'h0400;
      4'h6: angle_scale = 16'h0200;
      4'h7: angle_scale = 16'h5556;
      4'h8: angle_scale = 16'h2AAB;
      4'h9: angle_scale = 16'h1556;
      4'hA: angle_scale = 16'h071D;
      4'hB: angle_scale = 16'h3334;
      4'hC: angle_scale = 16'h199A;
      4'hD: angle_scale = 16'h0CCD;
      4'hE: angle_scale = 16'h051F;
      4'hF: angle_scale = 16'h0290;
    endcase
  endfunction

  // Reference scale in percent, 100 down to 30 in steps of ten
  function automatic logic [6:0] ref_percent(input logic [2:0] att);
    unique case (att)
      3'h0: ref_percent = 7'h64;
      3'h1: ref_percent = 7'h5A;
      3'h2: ref_percent = 7'h50;
      3'h3: ref_percent = 7'h46;
      3'h4: ref_percent = 7'h3C;
      3'h5: ref_percent = 7'h32;
      3'h6: ref_percent = 7'h28;
      3'h7: ref_percent = 7'h1E;
    endcase
  endfunction

endpackage

// file: design/quarter_sine.sv
// Quarter-wave sine in percent with a coarse table and linear interpolation
`timescale 1ns/10ps
module quarter_sine (
  input wire logic [8:0] angle_i,
  output logic [6:0] pct_o
);
  // Angle 0..256 spans 0..90 degrees; 33 points keep the table small
  localparam logic [6:0] TABLE [0:32] = '{
    7'd0, 7'd5, 7'd10, 7'd15, 7'd20, 7'd24, 7'd29, 7'd34, 7'd38, 7'd43, 7'd47,
    7'd51, 7'd56, 7'd60, 7'd63, 7'd67, 7'd71, 7'd74, 7'd77, 7'd80, 7'd83, 7'd86,
    7'd88, 7'd90, 7'd92, 7'd94, 7'd96, 7'd97, 7'd98, 7'd99, 7'd100, 7'd100, 7'd100
  };
  wire [5:0] seg = angle_i[8:3];
  wire [5:0] seg_next = (seg == 6'h20) ? seg : seg + 6'h01;
  wire [6:0] low_pt = TABLE[seg];
  wire [6:0] delta = TABLE[seg_next] - low_pt;
  wire [9:0] prod = {3'h0, delta} * {7'h00, angle_i[2:0]};
  assign pct_o = low_pt + prod[9:3];
endmodule

// file: design/serial_config_rx.sv
// Write-only serial receiver: LSB first, latched on the rising strobe edge
`timescale 1ns/10ps
module serial_config_rx (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic serial_clk_i,
  input wire logic serial_load_pulse_i,
  input wire logic serial_data_in_i,
  output logic word_valid_o,
  output logic [7:0] word_o
);
  import stepper_pkg::*;

  logic sclk_s1, sclk_s2, sclk_s3;
  logic stb_s1, stb_s2, stb_s3;
  logic dat_s1, dat_s2;
  logic [7:0] shift;
  logic [3:0] bit_cnt;

  wire sclk_rise = sclk_s2 & ~sclk_s3;
  wire stb_rise = stb_s2 & ~stb_s3;
  wire word_full = (bit_cnt == 4'(WORD_BITS));

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {stb_s1, stb_s2, stb_s3} <= 3'h7;
      {dat_s1, dat_s2} <= 2'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {serial_clk_i, sclk_s1, sclk_s2};
      {stb_s1, stb_s2, stb_s3} <= {serial_load_pulse_i, stb_s1, stb_s2};
      {dat_s1, dat_s2} <= {serial_data_in_i, dat_s1};
    end
  end

  // ********************************************************
  // Shift and latch
  // ********************************************************
  // Shifting right keeps only the last eight bits, whatever the count
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || clear_i) begin
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      word_valid_o <= 1'b0;
      word_o <= 8'h00;
    end else begin
      word_valid_o <= stb_rise && word_full;
      if (stb_rise && word_full) begin
        word_o <= shift;
      end
      if (stb_s2) begin
        bit_cnt <= 4'h0;
      end else if (sclk_rise) begin
        shift <= {dat_s2, shift[7:1]};
        bit_cnt <= word_full ? bit_cnt : bit_cnt + 4'h1;
      end
    end
  end

  property p_latch;
    @(posedge sys_clk_i) disable iff (!rst_n_i || clear_i)
      (stb_rise && word_full) |=> (word_valid_o && word_o == $past(shift));
  endproperty
  a_latch: assert property (p_latch) else $error("strobe rise did not latch word");

  property p_ignore;
    @(posedge sys_clk_i) disable iff (!rst_n_i || clear_i)
      stb_s2 ##1 stb_s2 |-> ($stable(shift) && bit_cnt == 4'h0);
  endproperty
  a_ignore: assert property (p_ignore) else $error("serial clock accepted while strobe high");
endmodule

// file: design/stepper_sequencer.sv
// Micro-step sequencer with serial configuration, flags and chopping gates
`timescale 1ns/10ps
module stepper_sequencer #(
  parameter int IDLE_SHORT_LIMIT = stepper_pkg::IDLE_SHORT_CYCLES,
  parameter int IDLE_LONG_LIMIT = stepper_pkg::IDLE_LONG_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_n_in_i,
  input wire logic step_i,
  input wire logic direction_select_i,
  input wire logic serial_clk_i,
  input wire logic serial_load_pulse_i,
  input wire logic serial_data_in_i,
  input wire logic overcurrent_i,
  input wire logic vm_undervoltage_i,
  input wire logic thermal_shutdown_i,
  input wire logic [1:0] current_sense_input_i,
  output logic [3:0] high_side_gate_out_o,
  output logic [3:0] low_side_gate_out_o,
  output logic [6:0] coil1_target_o,
  output logic coil1_negative_o,
  output logic [6:0] coil2_target_o,
  output logic coil2_negative_o,
  output logic [6:0] ref_scale_o,
  output logic origin_indicator_o,
  output logic origin_indicator_oe_o,
  output logic idle_timeout_flag_o,
  output logic idle_timeout_flag_oe_o,
  output logic fault_flag_o,
  output logic fault_flag_oe_o
);
  import stepper_pkg::*;

  // ********************************************************
  // Input synchronisers
  // ********************************************************
  logic sleep_s1, sleep_s2, step_s1, step_s2, step_s3, dir_s1, dir_s2;
  logic [2:0] fault_s1, fault_s2;
  logic [1:0] sense_s1, sense_s2;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {sleep_s1, sleep_s2, step_s1, step_s2, step_s3, dir_s1, dir_s2} <= 7'h00;
      {fault_s1, fault_s2, sense_s1, sense_s2} <= 10'h000;
    end else begin
      {sleep_s1, sleep_s2} <= {sleep_n_in_i, sleep_s1};
      {step_s1, step_s2, step_s3} <= {step_i, step_s1, step_s2};
      {dir_s1, dir_s2} <= {direction_select_i, dir_s1};
      fault_s1 <= {thermal_shutdown_i, vm_undervoltage_i, overcurrent_i};
      fault_s2 <= fault_s1;
      sense_s1 <= current_sense_input_i;
      sense_s2 <= sense_s1;
    end
  end

  wire logic_rst = !rst_n_i || !sleep_s2;
  wire active = !logic_rst;
  wire step_edge = step_s2 & ~step_s3;

  // ********************************************************
  // Serial configuration
  // ********************************************************
  logic word_valid;
  logic [7:0] word;

  serial_config_rx u_rx (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(logic_rst),
    .serial_clk_i(serial_clk_i),
    .serial_load_pulse_i(serial_load_pulse_i),
    .serial_data_in_i(serial_data_in_i),
    .word_valid_o(word_valid),
    .word_o(word)
  );

  logic [3:0] res_pending, res_active;
  logic [1:0] decay_pending;
  decay_t decay_active;
  fault_sel_t fault_sel;
  logic [2:0] ref_att;
  logic idle_sel;
  logic [1:0] chop_sel;

  wire wr_step_fault = word_valid && word[1:0] == ADDR_STEP_FAULT;
  wire wr_cur_time = word_valid && word[1:0] == ADDR_CURRENT_TIMEOUT;
  wire wr_chop = word_valid && word[1:0] == ADDR_CHOP;

  // Registers have no read path; the word is only ever stored
  always_ff @(posedge sys_clk_i) begin
    if (logic_rst) begin
      res_pending <= RES_RESET;
      fault_sel <= FSEL_OVERCURRENT;
      decay_pending <= DECAY_MIXED25;
      ref_att <= REF_ATT_RESET;
      idle_sel <= IDLE_SEL_RESET;
      chop_sel <= CHOP_SEL_RESET;
    end else begin
      if (wr_step_fault) begin
        res_pending <= word[RES_LSB +: 4];
        fault_sel <= fault_sel_t'(word[FAULT_SEL_LSB +: 2]);
      end
      if (wr_cur_time) begin
        ref_att <= word[REF_ATT_LSB +: 3];
        decay_pending <= word[DECAY_LSB +: 2];
        idle_sel <= word[IDLE_SEL_BIT];
      end
      if (wr_chop) begin
        chop_sel <= word[CHOP_SEL_LSB +: 2];
      end
    end
  end

  // ********************************************************
  // Step position
  // ********************************************************
  logic [1:0] quad;
  logic [7:0] pos_n;

  wire [7:0] quarter_steps = steps_per_quarter(res_pending);
  wire [7:0] last_step = quarter_steps - 8'h01;
  wire cw_wrap = pos_n >= last_step;
  wire ccw_wrap = pos_n == 8'h00;
  wire [7:0] next_n_cw = cw_wrap ? 8'h00 : pos_n + 8'h01;
  wire [7:0] next_n_ccw = ccw_wrap ? last_step : (pos_n > last_step ? last_step : pos_n - 8'h01);
  wire [7:0] next_n = dir_s2 ? next_n_ccw : next_n_cw;
  wire [1:0] next_quad = dir_s2 ? (ccw_wrap ? quad - 2'h1 : quad) : (cw_wrap ? quad + 2'h1 : quad);
  wire at_home = quad == 2'h0 && pos_n == 8'h00;

  // Resolution and decay are taken over only at a step edge, so a write
  // between steps never changes the angle of the step being held
  always_ff @(posedge sys_clk_i) begin
    if (logic_rst) begin
      quad <= 2'h0;
      pos_n <= 8'h00;
      res_active <= RES_RESET;
      decay_active <= DECAY_MIXED25;
    end else if (step_edge) begin
      quad <= next_quad;
      pos_n <= next_n;
      res_active <= res_pending;
      decay_active <= decay_t'(decay_pending);
    end
  end

  // ********************************************************
  // Current targets
  // ********************************************************
  wire [23:0] angle_prod = {16'h0000, pos_n} * {8'h00, angle_scale(res_active)};
  wire [8:0] angle_idx = angle_prod[16:8];
  wire [8:0] angle_comp = 9'h100 - angle_idx;
  logic [6:0] sin_pct, cos_pct;

  quarter_sine u_sin (
    .angle_i(angle_idx),
    .pct_o(sin_pct)
  );

  quarter_sine u_cos (
    .angle_i(angle_comp),
    .pct_o(cos_pct)
  );

  wire [6:0] next_ch1 = quad[0] ? sin_pct : cos_pct;
  wire [6:0] next_ch2 = quad[0] ? cos_pct : sin_pct;

  always_ff @(posedge sys_clk_i) begin
    if (logic_rst) begin
      coil1_target_o <= 7'h00;
      coil2_target_o <= 7'h00;
      coil1_negative_o <= 1'b0;
      coil2_negative_o <= 1'b0;
      ref_scale_o <= 7'h00;
      origin_indicator_oe_o <= 1'b0;
    end else begin
      coil1_target_o <= next_ch1;
      coil2_target_o <= next_ch2;
      coil1_negative_o <= quad[1] ^ quad[0];
      coil2_negative_o <= quad[1];
      ref_scale_o <= ref_percent(ref_att);
      origin_indicator_oe_o <= at_home;
    end
  end

  // ********************************************************
  // Idle timeout and fault flag
  // ********************************************************
  logic [IDLE_CNT_W-1:0] idle_cnt;
  wire [IDLE_CNT_W-1:0] idle_limit = idle_sel ? IDLE_CNT_W'(IDLE_LONG_LIMIT) : IDLE_CNT_W'(IDLE_SHORT_LIMIT);
  wire idle_expired = idle_cnt > idle_limit;
  logic fault_pick;

  always_comb begin
    unique case (fault_sel)
      FSEL_OVERCURRENT: fault_pick = fault_s2[0];
      FSEL_NONE: fault_pick = 1'b0;
      FSEL_UNDERVOLT: fault_pick = fault_s2[1];
      FSEL_THERMAL: fault_pick = fault_s2[2];
    endcase
  end

  // Counter saturates just past the selected limit so it never wraps back
  always_ff @(posedge sys_clk_i) begin
    if (logic_rst) begin
      idle_cnt <= '0;
      idle_timeout_flag_oe_o <= 1'b0;
      fault_flag_oe_o <= 1'b0;
    end else begin
      idle_cnt <= step_edge ? '0 : (idle_expired ? idle_cnt : idle_cnt + 1'b1);
      idle_timeout_flag_oe_o <= !step_edge && idle_expired;
      fault_flag_oe_o <= fault_pick;
    end
  end

  assign origin_indicator_o = 1'b0;
  assign idle_timeout_flag_o = 1'b0;
  assign fault_flag_o = 1'b0;

  // ********************************************************
  // Chopping
  // ********************************************************
  logic [CHOP_CNT_W-1:0] chop_cnt;
  wire [CHOP_CNT_W-1:0] chop_period = CHOP_CNT_W'(CHOP_BASE_CYCLES) * ({9'h000, chop_sel} + 11'h001);
  wire chop_wrap = chop_cnt == chop_period - 11'h001;
  wire [CHOP_CNT_W-1:0] slow_end = (decay_active == DECAY_MIXED25) ? chop_period - (chop_period >> 2)
                                                                   : chop_period >> 1;
  wire mixed = decay_active == DECAY_MIXED25 || decay_active == DECAY_MIXED50;
  wire fast_now = decay_active == DECAY_FAST || (mixed && chop_cnt >= slow_end);
  // Protection cuts the bridge regardless of which fault the flag shows
  wire drive_ok = active && fault_s2 == 3'h0;

  always_ff @(posedge sys_clk_i) begin
    if (logic_rst) begin
      chop_cnt <= '0;
    end else begin
      chop_cnt <= chop_wrap ? '0 : chop_cnt + 11'h001;
    end
  end

  wire [6:0] mag [2];
  wire neg [2];
  assign mag[0] = coil1_target_o;
  assign mag[1] = coil2_target_o;
  assign neg[0] = coil1_negative_o;
  assign neg[1] = coil2_negative_o;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    chop_state_t state;
    logic [1:0] hs, ls;
    // Index 0 is the A side, index 1 the B side of the coil
    wire [1:0] charge_hs = neg[c] ? 2'b10 : 2'b01;
    wire [1:0] charge_ls = neg[c] ? 2'b01 : 2'b10;
    wire [1:0] next_hs = (state == CHOP_CHARGE) ? charge_hs : (fast_now ? charge_ls : 2'b00);
    wire [1:0] next_ls = (state == CHOP_CHARGE) ? charge_ls : (fast_now ? charge_hs : 2'b11);

    always_ff @(posedge sys_clk_i) begin
      if (logic_rst) begin
        state <= CHOP_CHARGE;
        hs <= 2'b00;
        ls <= 2'b00;
      end else begin
        if (chop_wrap) begin
          state <= CHOP_CHARGE;
        end else if (state == CHOP_CHARGE && sense_s2[c]) begin
          state <= CHOP_DECAY;
        end
        hs <= (drive_ok && mag[c] != 7'h00) ? next_hs : 2'b00;
        ls <= (drive_ok && mag[c] != 7'h00) ? next_ls : 2'b00;
      end
    end
    assign high_side_gate_out_o[2*c +: 2] = hs;
    assign low_side_gate_out_o[2*c +: 2] = ls;
  end

  // ********************************************************
  // Checks
  // ********************************************************
  property p_home;
    @(posedge sys_clk_i) disable iff (!rst_n_i) active |=> (origin_indicator_oe_o == $past(at_home));
  endproperty
  a_home: assert property (p_home) else $error("origin indicator does not follow home");

  property p_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (active && !step_edge) ##1 active |-> ($stable(pos_n) && $stable(quad));
  endproperty
  a_hold: assert property (p_hold) else $error("position moved without step edge");

  property p_cw;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (active && step_edge && !dir_s2 && !cw_wrap) ##1 active |-> (pos_n == $past(pos_n) + 8'h01);
  endproperty
  a_cw: assert property (p_cw) else $error("clockwise step did not advance");

  property p_ccw;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (active && step_edge && dir_s2 && !ccw_wrap && pos_n <= last_step) ##1 active |-> (pos_n == $past(pos_n) - 8'h01);
  endproperty
  a_ccw: assert property (p_ccw) else $error("counter-clockwise step did not retreat");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (active && step_edge && !dir_s2 && cw_wrap) ##1 active |-> (pos_n == 8'h00 && quad == $past(quad) + 2'h1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("quadrant wrap wrong");

  property p_standby;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !active |=> (at_home && high_side_gate_out_o == 4'h0 && low_side_gate_out_o == 4'h0);
  endproperty
  a_standby: assert property (p_standby) else $error("standby left gates or position");

  property p_fault_cut;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (fault_s2 != 3'h0) |=> (high_side_gate_out_o == 4'h0 && low_side_gate_out_o == 4'h0);
  endproperty
  a_fault_cut: assert property (p_fault_cut) else $error("gates driven during fault");

  property p_idle;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (active && !step_edge && idle_expired) |=> idle_timeout_flag_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag not raised after timeout");

  property p_idle_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i) step_edge |=> !idle_timeout_flag_oe_o;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle flag held after step");

  property p_fault_none;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (fault_sel == FSEL_NONE) |=> !fault_flag_oe_o;
  endproperty
  a_fault_none: assert property (p_fault_none) else $error("fault flag with none selected");

  property p_res_defer;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (active && !step_edge) ##1 active |-> $stable(res_active);
  endproperty
  a_res_defer: assert property (p_res_defer) else $error("resolution changed without step");
endmodule

// file: sim/host_model.sv
// Host-side model: step pulses and LSB-first serial configuration writes
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk_i,
  output logic step_o = 1'b0,
  output logic dir_o = 1'b0,
  output logic sclk_o = 1'b0,
  output logic stb_o = 1'b1,
  output logic serial_data_in_o = 1'b0
);
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Nine clocks per frame: bit 0 is junk that the last eight must push out
  task automatic send(input logic [8:0] w);
    cyc(1);
    stb_o <= 1'b0;
    cyc(6);
    for (int i = 0; i < 9; i++) begin
      serial_data_in_o <= w[i];
      sclk_o <= 1'b0;
      cyc(4);
      sclk_o <= 1'b1;
      cyc(4);
    end
    // Strobe rises a full link period after the last rise, well past its setup time
    sclk_o <= 1'b0;
    cyc(4);
    stb_o <= 1'b1;
    serial_data_in_o <= ~serial_data_in_o;
    cyc(10);
    #1;
  endtask
  task automatic step(input logic d);
    cyc(1);
    dir_o <= d;
    cyc(4);
    step_o <= 1'b1;
    cyc(6);
    step_o <= 1'b0;
    cyc(8);
    #1;
  endtask
endmodule

// file: sim/tb_microstep_sequencer.sv
// Self-checking bench for the micro-step sequencer
`timescale 1ns/10ps
module tb_microstep_sequencer;
  import stepper_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sleep_n = 1'b0, ovc = 1'b0, uv = 1'b0, ts = 1'b0;
  logic [1:0] sense = 2'h0;
  logic step, dir, sclk, stb, serial_data_in, c1n, c2n, mo, idle_timeout_flag, fl;
  logic [6:0] c1, c2, rs;
  logic [3:0] hs, ls;
  logic od_mo, od_sdo, od_fl;
  logic [16:0] lfsr = 17'h15E1F;
  int failures = 0, compares = 0;
  always #12.5 clk = ~clk;
  host_model host (.sys_clk_i(clk), .step_o(step), .dir_o(dir), .sclk_o(sclk), .stb_o(stb), .serial_data_in_o(serial_data_in));
  stepper_sequencer #(.IDLE_SHORT_LIMIT(200), .IDLE_LONG_LIMIT(400)) dut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .sleep_n_in_i(sleep_n), .step_i(step), .direction_select_i(dir), .serial_clk_i(sclk),
    .serial_load_pulse_i(stb), .serial_data_in_i(serial_data_in), .overcurrent_i(ovc), .vm_undervoltage_i(uv),
    .thermal_shutdown_i(ts), .current_sense_input_i(sense), .high_side_gate_out_o(hs), .low_side_gate_out_o(ls),
    .coil1_target_o(c1), .coil1_negative_o(c1n), .coil2_target_o(c2), .coil2_negative_o(c2n),
    .ref_scale_o(rs), .origin_indicator_o(od_mo), .origin_indicator_oe_o(mo), .idle_timeout_flag_o(od_sdo),
    .idle_timeout_flag_oe_o(idle_timeout_flag), .fault_flag_o(od_fl), .fault_flag_oe_o(fl));
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // Steps in one quarter of the electrical cycle for each resolution code
  function automatic int quarter_len(input logic [3:0] r);
    int tab [16] = '{2, 4, 8, 16, 32, 64, 128, 3, 6, 12, 36, 5, 10, 20, 50, 100};
    return tab[r];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Only the nonzero channel's sign is defined at a quadrant boundary
  task automatic quad(input int q);
    check(q[0] ? {1'b0, c1, c2n, c2} : {c1n, c1, 1'b0, c2}, q[0] ? {8'h00, q == 3, 7'h64} : {q == 2, 7'h64, 8'h00});
  endtask
  task automatic hold(input int n);
    host.cyc(n);
    #1;
  endtask
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    sleep_n <= 1'b1;
    hold(10);
    quad(0);
    check(16'(mo), 16'h1);
    check(16'({hs, ls}), 16'h0012);
    check(16'({od_mo, od_sdo, od_fl}), 16'h0000);
    @(posedge clk);
    sense <= 2'h1;
    hold(6);
    check(16'({hs, ls}), 16'h0003);
    host.send({8'h00, 1'b1});
    for (int i = 1; i <= 8; i++) begin
      @(posedge clk);
      sense <= lfsr[1:0];
      lfsr = lfsr_next(lfsr);
      host.step(1'b0);
      if (!i[0]) quad(i / 2 % 4);
      check(16'(mo), 16'(i == 8));
    end
    host.step(1'b1);
    host.step(1'b1);
    quad(3);
    for (int i = 0; i < 8; i++) begin
      logic [2:0] a;
      a = i == 0 ? 3'h7 : lfsr[2:0];
      lfsr = lfsr_next(lfsr);
      host.send({3'h0, a, 2'h1, lfsr[3]});
      check(16'(rs), 16'(100 - 10 * a));
    end
    for (int k = 0; k < 8; k++) begin
      host.send({2'(k), 6'h00, 1'b0});
      @(posedge clk);
      {ovc, uv, ts} <= lfsr[2:0];
      lfsr = lfsr_next(lfsr);
      hold(6);
      check(16'(fl), 16'(k % 4 == 0 ? ovc : k % 4 == 2 ? uv : k % 4 == 3 ? ts : 1'b0));
    end
    @(posedge clk);
    {ovc, uv, ts} <= 3'h0;
    for (int s = 0; s < 2; s++) begin
      host.send({s[0], 7'h01, 1'b0});
      host.step(1'b0);
      check(16'(idle_timeout_flag), 16'h0);
      hold(180 + 200 * s);
      check(16'(idle_timeout_flag), 16'h0);
      hold(30);
      check(16'(idle_timeout_flag), 16'h1);
    end
    @(posedge clk);
    sleep_n <= 1'b0;
    ovc <= 1'b1;
    hold(6);
    check({1'b0, c1, 1'b0, c2}, 16'h0000);
    check(16'({hs, ls}), 16'h0000);
    host.send({8'h40, 1'b0});
    @(posedge clk);
    sleep_n <= 1'b1;
    hold(8);
    quad(0);
    check(16'(fl), 16'h1);
    check(16'({hs, ls}), 16'h0000);
    // One full quarter at a new resolution must land exactly on the next quadrant
    for (int i = 0; i < 2; i++) begin
      logic [3:0] r;
      r = i == 0 ? 4'hF : lfsr[3:0];
      lfsr = lfsr_next(lfsr);
      host.send({2'h0, r, 2'h0, 1'b1});
      for (int j = 0; j < quarter_len(r); j++) begin
        host.step(1'b0);
      end
      quad(i + 1);
      check(16'(mo), 16'h0);
    end
    results;
  end
  initial begin
    #500000;
    failures++;
    results;
  end
endmodule
